// ### logic/axis_status_pkg.sv
package axis_status_pkg;
   localparam int NUM_AXES = 8;
   localparam int AXIS_IDX_W = 3;

   typedef enum logic [2:0] {
      MODE_AUTO    = 3'b000,
      MODE_JOG     = 3'b001,
      MODE_HANDLE  = 3'b010,
      MODE_INCR    = 3'b011,
      MODE_RANDOM  = 3'b100,
      MODE_REF_RET = 3'b101
   } op_mode_e;

   typedef enum logic [2:0] {
      CMD_MOVE   = 3'b000,
      CMD_DWELL  = 3'b001,
      CMD_PRESET = 3'b010,
      CMD_REF1   = 3'b011,
      CMD_REF2   = 3'b100
   } cmd_kind_e;

   typedef enum logic [1:0] {
      RR_IDLE  = 2'b00,
      RR_FAST  = 2'b01,
      RR_CREEP = 2'b10,
      RR_HIGH  = 2'b11
   } ref_ret_e;

   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic       BIT_RST   = 1'b0;
   localparam int         SYNC_STAGES = 2;
endpackage

// ### logic/axis_ctl_if.sv
`timescale 1ns/1ps
interface axis_ctl_if;
   logic       lock;
   logic [7:0] move_plus;
   logic [7:0] move_minus;

   modport src (output lock, output move_plus, output move_minus);
   modport dst (input lock, input move_plus, input move_minus);
endinterface

// ### logic/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ### logic/motion_dir_flag.sv
`timescale 1ns/1ps
module motion_dir_flag #(
   parameter int AXIS = 0
) (
   input  wire logic clk,
   input  wire logic reset_n,
   axis_ctl_if.dst   ctl,
   output logic      plus_q,
   output logic      minus_q
);
   logic plus_d;
   logic minus_d;

   // Actual travel, any mode; forced low under machine lock
   assign plus_d  = ctl.move_plus[AXIS] & ~ctl.move_minus[AXIS] & ~ctl.lock;
   assign minus_d = ctl.move_minus[AXIS] & ~ctl.move_plus[AXIS] & ~ctl.lock;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         plus_q  <= axis_status_pkg::BIT_RST;
         minus_q <= axis_status_pkg::BIT_RST;
      end else begin
         plus_q  <= plus_d;
         minus_q <= minus_d;
      end
   end
endmodule

// ### logic/axis_status_flag_logic.sv
`timescale 1ns/1ps
module axis_status_flag_logic #(
   parameter int AXES = axis_status_pkg::NUM_AXES
) (
   // Clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RESET_N,
   // Asynchronous machine pins
   input  wire logic                 EMG_STOP,
   input  wire logic [AXES-1:0]      SERVO_ALARM,
   // Controller state
   input  wire logic [2:0]           OP_MODE,
   input  wire logic                 CTRL_RESET,
   input  wire logic                 MACHINE_LOCK,
   input  wire logic                 AUTO_PAUSE,
   input  wire logic                 POWER_DIAG_OK,
   input  wire logic                 MANDOG_SEL,
   input  wire logic [AXES-1:0]      SERVO_OFF,
   // Manual feed selection
   input  wire logic [AXES-1:0]      FEED_SELECT_PLUS,
   input  wire logic [AXES-1:0]      FEED_SELECT_MINUS,
   input  wire logic [2:0]           HANDLE_AXIS_NUMBER,
   input  wire logic                 HANDLE_VALID,
   input  wire logic                 RANDOM_FEED_STROBE,
   input  wire logic                 RANDOM_FEED_STOP,
   input  wire logic [AXES-1:0]      RANDOM_FEED_AXES,
   // Motion events
   input  wire logic [AXES-1:0]      AUTO_MOVE_CMD,
   input  wire logic [2:0]           AUTO_CMD_KIND,
   input  wire logic [AXES-1:0]      MOTION_DONE,
   input  wire logic [AXES-1:0]      NEAR_DOG,
   input  wire logic [AXES-1:0]      REF1_ARRIVED,
   input  wire logic [AXES-1:0]      REF2_ARRIVED,
   input  wire logic [AXES-1:0]      MOVING_PLUS,
   input  wire logic [AXES-1:0]      MOVING_MINUS,
   // Status flags
   output logic      [AXES-1:0]      SERVO_READY,
   output logic      [AXES-1:0]      AXIS_SELECTED_FLAG,
   output logic      [AXES-1:0]      PLUS_MOTION_FLAG,
   output logic      [AXES-1:0]      MINUS_MOTION_FLAG,
   output logic      [AXES-1:0]      FIRST_REF_REACHED_FLAG,
   output logic      [AXES-1:0]      SECOND_REF_REACHED_FLAG,
   // Reference return status
   output logic      [AXES-1:0]      RETURN_CREEP,
   output logic      [AXES-1:0]      COORD_ESTABLISHED
);
   axis_ctl_if ctl ();

   logic [AXES-1:0] alarm_s;
   logic            emg_s;
   logic [2:0]      mode_q;
   logic            diag_done_q;
   logic [AXES-1:0] ready_q;
   logic [AXES-1:0] ready_d;
   logic [AXES-1:0] sel_q;
   logic [AXES-1:0] sel_d;
   logic [AXES-1:0] latch_q;
   logic [AXES-1:0] latch_d;
   logic [AXES-1:0] feed_q;
   logic [AXES-1:0] g28_q;
   logic [AXES-1:0] g28_d;
   logic [AXES-1:0] g30_q;
   logic [AXES-1:0] g30_d;
   logic [AXES-1:0] ref1_q;
   logic [AXES-1:0] ref1_d;
   logic [AXES-1:0] ref2_q;
   logic [AXES-1:0] ref2_d;
   logic [AXES-1:0] coord_q;
   logic [AXES-1:0] coord_d;
   axis_status_pkg::ref_ret_e rr_q [AXES];
   axis_status_pkg::ref_ret_e rr_d [AXES];

   // Pin inputs pass two flip-flops
   level_sync #(.WIDTH(AXES + 1)) u_sync (
      .clk     (CLK),
      .reset_n (RESET_N),
      .d       ({EMG_STOP, SERVO_ALARM}),
      .q       ({emg_s, alarm_s})
   );

   // Mode decode
   wire mode_chg   = OP_MODE != mode_q;
   wire is_auto    = OP_MODE == axis_status_pkg::MODE_AUTO;
   wire is_jog     = OP_MODE == axis_status_pkg::MODE_JOG;
   wire is_handle  = OP_MODE == axis_status_pkg::MODE_HANDLE;
   wire is_incr    = OP_MODE == axis_status_pkg::MODE_INCR;
   wire is_random  = OP_MODE == axis_status_pkg::MODE_RANDOM;
   wire is_ref     = OP_MODE == axis_status_pkg::MODE_REF_RET;
   wire manual_ok  = ~MACHINE_LOCK;
   wire clear_all  = CTRL_RESET | emg_s;

   // Command kind decode
   wire kind_moves = AUTO_CMD_KIND != axis_status_pkg::CMD_DWELL
                   && AUTO_CMD_KIND != axis_status_pkg::CMD_PRESET;
   wire kind_g28   = AUTO_CMD_KIND == axis_status_pkg::CMD_REF1;
   wire kind_g30   = AUTO_CMD_KIND == axis_status_pkg::CMD_REF2;

   // Per-axis derived terms
   wire [AXES-1:0] feed_now   = FEED_SELECT_PLUS | FEED_SELECT_MINUS;
   wire [AXES-1:0] feed_rise  = feed_now & ~feed_q;
   wire [AXES-1:0] moving     = MOVING_PLUS | MOVING_MINUS;
   wire [AXES-1:0] auto_start = AUTO_MOVE_CMD & {AXES{kind_moves & is_auto}};
   wire [AXES-1:0] halt       = alarm_s | {AXES{emg_s}};
   wire [AXES-1:0] handle_hit = (AXES)'(1) << HANDLE_AXIS_NUMBER;

   // Latched selection used by automatic, incremental and random feed
   wire [AXES-1:0] latch_set  = is_auto   ? auto_start
                              : is_incr   ? feed_rise & {AXES{manual_ok}}
                              : is_random ? RANDOM_FEED_AXES & {AXES{RANDOM_FEED_STROBE & manual_ok}}
                              : '0;
   wire [AXES-1:0] latch_clr  = MOTION_DONE | {AXES{is_auto & AUTO_PAUSE}};
   // A mode change drops the old selection but not a request raised in that same cycle
   wire [AXES-1:0] latch_keep = mode_chg ? '0 : latch_q & ~latch_clr;

   // Random feed stop is deliberately unused by the selection flag
   wire            stop_unused = RANDOM_FEED_STOP;

   // Drive ready: level from diagnosis, alarm, stop and servo-off
   always_comb begin
      ready_d = {AXES{diag_done_q}} & ~alarm_s & ~SERVO_OFF & {AXES{~emg_s}};
   end

   // Selection latch; set wins over a completion or a mode change in the same cycle
   always_comb begin
      latch_d = latch_q;
      if (clear_all) begin
         latch_d = '0;
      end else begin
         latch_d = latch_keep | latch_set;
      end
   end

   // Reference return sequencer per axis
   always_comb begin
      for (int i = 0; i < AXES; i++) begin
         rr_d[i] = rr_q[i];
         if (!is_ref || clear_all || halt[i]) begin
            rr_d[i] = axis_status_pkg::RR_IDLE;
         end else begin
            unique case (rr_q[i])
               axis_status_pkg::RR_IDLE: begin
                  if (feed_rise[i] && manual_ok) begin
                     if (coord_q[i] || !MANDOG_SEL) begin
                        rr_d[i] = axis_status_pkg::RR_HIGH;
                     end else begin
                        rr_d[i] = axis_status_pkg::RR_FAST;
                     end
                  end
               end
               // Dog search at rapid; dropping the select abandons it
               axis_status_pkg::RR_FAST: begin
                  if (!feed_now[i]) begin
                     rr_d[i] = axis_status_pkg::RR_IDLE;
                  end else if (NEAR_DOG[i]) begin
                     rr_d[i] = axis_status_pkg::RR_CREEP;
                  end
               end
               // Creep runs on to the position with or without the select
               axis_status_pkg::RR_CREEP: begin
                  if (REF1_ARRIVED[i]) begin
                     rr_d[i] = axis_status_pkg::RR_IDLE;
                  end
               end
               // High-speed return needs the select held until arrival
               axis_status_pkg::RR_HIGH: begin
                  if (REF1_ARRIVED[i] || !feed_now[i]) begin
                     rr_d[i] = axis_status_pkg::RR_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Selected flag per mode
   always_comb begin
      for (int i = 0; i < AXES; i++) begin
         sel_d[i] = 1'b0;
         if (!clear_all) begin
            unique case (1'b1)
               is_auto:   sel_d[i] = latch_d[i];
               is_jog:    sel_d[i] = feed_now[i] & manual_ok;
               // Manual modes: lock masks every source, latched ones included
               is_ref:    sel_d[i] = (feed_now[i] | (rr_d[i] == axis_status_pkg::RR_CREEP))
                                   & manual_ok;
               is_handle: sel_d[i] = handle_hit[i] & HANDLE_VALID & manual_ok;
               is_incr:   sel_d[i] = latch_d[i] & manual_ok;
               is_random: sel_d[i] = latch_d[i] & manual_ok;
               default:   sel_d[i] = 1'b0;
            endcase
         end
      end
   end
   // Feedrate zero, interlock and servo-off hold no term above: flag keeps its state

   // Pending automatic return commands
   always_comb begin
      g28_d = g28_q;
      g30_d = g30_q;
      if (clear_all) begin
         g28_d = '0;
         g30_d = '0;
      end else begin
         g28_d = (g28_q & ~MOTION_DONE) | (auto_start & {AXES{kind_g28}});
         g30_d = (g30_q & ~MOTION_DONE) | (auto_start & {AXES{kind_g30}});
      end
   end

   // Reference reached flags; arrival wins over a clear in the same cycle
   always_comb begin
      ref1_d  = ref1_q;
      ref2_d  = ref2_q;
      coord_d = coord_q;
      for (int i = 0; i < AXES; i++) begin
         if (moving[i] || halt[i]) begin
            ref1_d[i] = 1'b0;
            ref2_d[i] = 1'b0;
         end
         if (REF1_ARRIVED[i] && ((is_ref && rr_q[i] != axis_status_pkg::RR_IDLE) || g28_q[i])) begin
            ref1_d[i]  = 1'b1;
            coord_d[i] = 1'b1;
         end
         if (REF2_ARRIVED[i] && g30_q[i]) begin
            ref2_d[i] = 1'b1;
         end
      end
   end

   // State registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mode_q      <= axis_status_pkg::MODE_AUTO;
         diag_done_q <= axis_status_pkg::BIT_RST;
         feed_q      <= axis_status_pkg::FLAGS_RST;
         latch_q     <= axis_status_pkg::FLAGS_RST;
         g28_q       <= axis_status_pkg::FLAGS_RST;
         g30_q       <= axis_status_pkg::FLAGS_RST;
         coord_q     <= axis_status_pkg::FLAGS_RST;
      end else begin
         mode_q      <= OP_MODE;
         diag_done_q <= diag_done_q | POWER_DIAG_OK;
         feed_q      <= feed_now;
         latch_q     <= latch_d;
         g28_q       <= g28_d;
         g30_q       <= g30_d;
         coord_q     <= coord_d;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < AXES; i++) begin
            rr_q[i] <= axis_status_pkg::RR_IDLE;
         end
      end else begin
         rr_q <= rr_d;
      end
   end

   // Registered flag outputs
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ready_q <= axis_status_pkg::FLAGS_RST;
         sel_q   <= axis_status_pkg::FLAGS_RST;
         ref1_q  <= axis_status_pkg::FLAGS_RST;
         ref2_q  <= axis_status_pkg::FLAGS_RST;
      end else begin
         ready_q <= ready_d;
         sel_q   <= sel_d;
         ref1_q  <= ref1_d;
         ref2_q  <= ref2_d;
      end
   end

   // Direction flags, one instance per axis
   assign ctl.lock       = MACHINE_LOCK;
   assign ctl.move_plus  = MOVING_PLUS;
   assign ctl.move_minus = MOVING_MINUS;

   for (genvar g = 0; g < AXES; g++) begin : g_dir
      motion_dir_flag #(.AXIS(g)) u_dir (
         .clk     (CLK),
         .reset_n (RESET_N),
         .ctl     (ctl.dst),
         .plus_q  (PLUS_MOTION_FLAG[g]),
         .minus_q (MINUS_MOTION_FLAG[g])
      );
   end

   // Creep flag is a registered view of the sequencer state
   logic [AXES-1:0] creep_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         creep_q <= axis_status_pkg::FLAGS_RST;
      end else begin
         for (int i = 0; i < AXES; i++) begin
            creep_q[i] <= rr_d[i] == axis_status_pkg::RR_CREEP;
         end
      end
   end

   assign SERVO_READY             = ready_q;
   assign AXIS_SELECTED_FLAG      = sel_q;
   assign FIRST_REF_REACHED_FLAG  = ref1_q;
   assign SECOND_REF_REACHED_FLAG = ref2_q;
   assign RETURN_CREEP            = creep_q;
   assign COORD_ESTABLISHED       = coord_q;
endmodule

// ### test/axis_status_chk.sv
`timescale 1ns/1ps
module axis_status_chk #(
   parameter int AXES = 8
) (
   input wire logic            CLK,
   input wire logic            RESET_N,
   input wire logic            EMG_STOP,
   input wire logic [2:0]      OP_MODE,
   input wire logic            CTRL_RESET,
   input wire logic            MACHINE_LOCK,
   input wire logic [AXES-1:0] SERVO_OFF,
   input wire logic [2:0]      HANDLE_AXIS_NUMBER,
   input wire logic            HANDLE_VALID,
   input wire logic [AXES-1:0] AUTO_MOVE_CMD,
   input wire logic [2:0]      AUTO_CMD_KIND,
   input wire logic [AXES-1:0] MOVING_PLUS,
   input wire logic [AXES-1:0] MOVING_MINUS,
   input wire logic [AXES-1:0] SERVO_READY,
   input wire logic [AXES-1:0] AXIS_SELECTED_FLAG,
   input wire logic [AXES-1:0] PLUS_MOTION_FLAG,
   input wire logic [AXES-1:0] MINUS_MOTION_FLAG,
   input wire logic [AXES-1:0] FIRST_REF_REACHED_FLAG,
   input wire logic [AXES-1:0] SECOND_REF_REACHED_FLAG
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // Stop pins pass a synchroniser, so only a quiet stretch rules them out
   sequence s_calm;
      (!EMG_STOP && !CTRL_RESET)[*4];
   endsequence
   property p_plus;
      !MACHINE_LOCK |=> PLUS_MOTION_FLAG == $past(MOVING_PLUS);
   endproperty
   a_plus: assert property (p_plus) else $error("plus flag differs from travel");
   property p_minus;
      !MACHINE_LOCK |=> MINUS_MOTION_FLAG == $past(MOVING_MINUS);
   endproperty
   a_minus: assert property (p_minus) else $error("minus flag differs from travel");
   property p_lock;
      MACHINE_LOCK |=> PLUS_MOTION_FLAG == '0 && MINUS_MOTION_FLAG == '0;
   endproperty
   a_lock: assert property (p_lock) else $error("direction flag under lock");
   property p_soff;
      SERVO_OFF != '0 |=> (SERVO_READY & $past(SERVO_OFF)) == '0;
   endproperty
   a_soff: assert property (p_soff) else $error("ready kept under servo off");
   property p_emg;
      EMG_STOP[*5] |-> SERVO_READY == '0 && AXIS_SELECTED_FLAG == '0
         && FIRST_REF_REACHED_FLAG == '0 && SECOND_REF_REACHED_FLAG == '0;
   endproperty
   a_emg: assert property (p_emg) else $error("flags kept under stop");
   property p_crst;
      CTRL_RESET && AUTO_MOVE_CMD == '0 && OP_MODE == axis_status_pkg::MODE_AUTO |=> AXIS_SELECTED_FLAG == '0;
   endproperty
   a_crst: assert property (p_crst) else $error("selection kept after reset");
   property p_auto;
      s_calm ##0 (OP_MODE == axis_status_pkg::MODE_AUTO && AUTO_CMD_KIND == axis_status_pkg::CMD_MOVE)
         |=> (AXIS_SELECTED_FLAG & $past(AUTO_MOVE_CMD)) == $past(AUTO_MOVE_CMD);
   endproperty
   a_auto: assert property (p_auto) else $error("move command not selected");
   property p_dwell;
      OP_MODE == axis_status_pkg::MODE_AUTO && AXIS_SELECTED_FLAG == '0
         && AUTO_CMD_KIND inside {axis_status_pkg::CMD_DWELL, axis_status_pkg::CMD_PRESET}
         |=> AXIS_SELECTED_FLAG == '0;
   endproperty
   a_dwell: assert property (p_dwell) else $error("dwell or preset selected");
   property p_handle;
      s_calm ##0 (OP_MODE == axis_status_pkg::MODE_HANDLE && !MACHINE_LOCK) |=> AXIS_SELECTED_FLAG ==
         ($past(HANDLE_VALID) ? AXES'(1) << $past(HANDLE_AXIS_NUMBER) : '0);
   endproperty
   a_handle: assert property (p_handle) else $error("handle selection wrong");
   property p_mlock;
      MACHINE_LOCK && OP_MODE != axis_status_pkg::MODE_AUTO |=> AXIS_SELECTED_FLAG == '0;
   endproperty
   a_mlock: assert property (p_mlock) else $error("manual selection under lock");
endmodule

bind axis_status_flag_logic axis_status_chk #(.AXES(AXES)) u_chk (
   .CLK(CLK), .RESET_N(RESET_N), .EMG_STOP(EMG_STOP), .OP_MODE(OP_MODE), .CTRL_RESET(CTRL_RESET),
   .MACHINE_LOCK(MACHINE_LOCK), .SERVO_OFF(SERVO_OFF), .HANDLE_AXIS_NUMBER(HANDLE_AXIS_NUMBER),
   .HANDLE_VALID(HANDLE_VALID), .AUTO_MOVE_CMD(AUTO_MOVE_CMD), .AUTO_CMD_KIND(AUTO_CMD_KIND),
   .MOVING_PLUS(MOVING_PLUS), .MOVING_MINUS(MOVING_MINUS), .SERVO_READY(SERVO_READY),
   .AXIS_SELECTED_FLAG(AXIS_SELECTED_FLAG), .PLUS_MOTION_FLAG(PLUS_MOTION_FLAG),
   .MINUS_MOTION_FLAG(MINUS_MOTION_FLAG), .FIRST_REF_REACHED_FLAG(FIRST_REF_REACHED_FLAG),
   .SECOND_REF_REACHED_FLAG(SECOND_REF_REACHED_FLAG)
);

// ### test/axis_motion_model.sv
`timescale 1ns/1ps
module axis_motion_model (
   input wire logic       clk,
   input wire logic [7:0] go,
   input wire logic       neg,
   input wire logic [7:0] len,
   input wire logic       hold,
   output logic     [7:0] mv_plus,
   output logic     [7:0] mv_minus,
   output logic     [7:0] done
);
   logic [7:0] act_q = '0;
   logic [7:0] cnt_q = '0;
   logic       neg_q = 1'b0;
   initial done = '0;
   // Hold stands for a zero override: travel stops but the motion stays open
   always @(posedge clk) begin
      done <= '0;
      if (go != '0) begin
         act_q <= go;
         cnt_q <= len;
         neg_q <= neg;
      end else if (!hold && cnt_q > 8'h01) begin
         cnt_q <= cnt_q - 8'h01;
      end else if (!hold && cnt_q == 8'h01) begin
         done <= act_q;
         cnt_q <= '0;
      end
   end
   assign mv_plus  = (cnt_q != '0 && !hold && !neg_q) ? act_q : '0;
   assign mv_minus = (cnt_q != '0 && !hold && neg_q) ? act_q : '0;
endmodule

// ### test/axis_status_flag_logic_test.sv
`timescale 1ns/1ps
module axis_status_flag_logic_test;
   logic       CLK;
   logic       RESET_N;
   logic       emg, crst, lock, pause, diag, mdog, hval, stb, stp, neg, hold;
   logic [7:0] alm, soff, fsp, fsm, rax, amc, ndog, r1, r2, go, len;
   logic [2:0] mode, hax, kind;
   logic [7:0] rdy, sel, mvp, mvm, f1, f2, creep, coord, mp, mm, done;
   int         err_count, n_tests, tick;
   axis_status_flag_logic u_dut (
      .CLK(CLK), .RESET_N(RESET_N), .EMG_STOP(emg), .SERVO_ALARM(alm), .OP_MODE(mode),
      .CTRL_RESET(crst), .MACHINE_LOCK(lock), .AUTO_PAUSE(pause), .POWER_DIAG_OK(diag),
      .MANDOG_SEL(mdog), .SERVO_OFF(soff), .FEED_SELECT_PLUS(fsp), .FEED_SELECT_MINUS(fsm),
      .HANDLE_AXIS_NUMBER(hax), .HANDLE_VALID(hval), .RANDOM_FEED_STROBE(stb),
      .RANDOM_FEED_STOP(stp), .RANDOM_FEED_AXES(rax), .AUTO_MOVE_CMD(amc), .AUTO_CMD_KIND(kind),
      .MOTION_DONE(done), .NEAR_DOG(ndog), .REF1_ARRIVED(r1), .REF2_ARRIVED(r2),
      .MOVING_PLUS(mp), .MOVING_MINUS(mm), .SERVO_READY(rdy), .AXIS_SELECTED_FLAG(sel),
      .PLUS_MOTION_FLAG(mvp), .MINUS_MOTION_FLAG(mvm), .FIRST_REF_REACHED_FLAG(f1),
      .SECOND_REF_REACHED_FLAG(f2), .RETURN_CREEP(creep), .COORD_ESTABLISHED(coord)
   );
   axis_motion_model u_far (
      .clk(CLK), .go(go), .neg(neg), .len(len), .hold(hold), .mv_plus(mp), .mv_minus(mm), .done(done)
   );
   task automatic cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic move(input logic [7:0] ax, input logic [2:0] kd, input logic ng);
      kind = kd;
      amc = ax;
      go = ax;
      neg = ng;
      cyc(1);
      amc = '0;
      go = '0;
   endtask
   // Bounded wait for the far side to finish, then one edge for the flag to fall
   task automatic wait_done();
      int k;
      k = 0;
      while (done === '0 && k < 200) begin
         cyc(1);
         k++;
      end
      cyc(1);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      tick++;
      if (tick > 5000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      {emg, crst, lock, pause, diag, mdog, hval, stb, stp, neg, hold, RESET_N} = '0;
      {alm, soff, fsp, fsm, rax, amc, ndog, r1, r2, go, mode, hax, kind} = '0;
      len = 8'h06;
      cyc(10);
      RESET_N = 1'b1;
      chk(rdy | sel | mvp | mvm | f1 | f2 | creep | coord, 8'h00);
      cyc(1);
      diag = 1'b1;
      cyc(1);
      diag = 1'b0;
      cyc(2);
      chk(rdy, 8'hFF);
      soff = 8'h04;
      cyc(1);
      chk(rdy, 8'hFB);
      soff = '0;
      cyc(1);
      chk(rdy, 8'hFF);
      alm = 8'h20;
      cyc(4);
      chk(rdy, 8'hDF);
      alm = '0;
      cyc(4);
      chk(rdy, 8'hFF);
      $display("test ready ended");
      move(8'h01, axis_status_pkg::CMD_MOVE, 1'b0);
      chk(sel, 8'h01);
      soff = 8'h01;
      cyc(1);
      chk(mvp, 8'h01);
      chk(mvm, 8'h00);
      hold = 1'b1;
      cyc(2);
      chk(sel, 8'h01);
      chk(mvp, 8'h00);
      hold = 1'b0;
      soff = '0;
      wait_done();
      chk(sel, 8'h00);
      move(8'h80, axis_status_pkg::CMD_MOVE, 1'b1);
      cyc(1);
      chk(mvm, 8'h80);
      chk(mvp, 8'h00);
      pause = 1'b1;
      cyc(1);
      chk(sel, 8'h00);
      pause = 1'b0;
      wait_done();
      for (int k = 1; k < 3; k++) begin
         kind = 3'(k);
         amc = 8'h02;
         cyc(1);
         amc = '0;
         chk(sel, 8'h00);
      end
      $display("test automatic ended");
      lock = 1'b1;
      move(8'h08, axis_status_pkg::CMD_MOVE, 1'b0);
      chk(sel, 8'h08);
      cyc(1);
      chk(mvp, 8'h00);
      wait_done();
      mode = axis_status_pkg::MODE_JOG;
      fsp = 8'h08;
      cyc(1);
      chk(sel, 8'h00);
      lock = 1'b0;
      cyc(1);
      chk(sel, 8'h08);
      fsp = '0;
      fsm = 8'h08;
      cyc(1);
      chk(sel, 8'h08);
      fsm = '0;
      cyc(1);
      chk(sel, 8'h00);
      mode = axis_status_pkg::MODE_HANDLE;
      for (int i = 0; i < 8; i++) begin
         hax = 3'(i);
         hval = 1'b1;
         cyc(1);
         chk(sel, 8'h01 << i);
         hval = 1'b0;
         cyc(1);
         chk(sel, 8'h00);
      end
      mode = axis_status_pkg::MODE_INCR;
      fsp = 8'h10;
      go = 8'h10;
      neg = 1'b0;
      cyc(1);
      go = '0;
      chk(sel, 8'h10);
      fsp = '0;
      cyc(1);
      chk(sel, 8'h10);
      wait_done();
      chk(sel, 8'h00);
      mode = axis_status_pkg::MODE_RANDOM;
      rax = 8'h20;
      {stp, stb} = 2'b11;
      go = 8'h20;
      cyc(1);
      {stb, go} = '0;
      chk(sel, 8'h20);
      stp = 1'b0;
      cyc(2);
      chk(sel, 8'h20);
      wait_done();
      chk(sel, 8'h00);
      $display("test manual ended");
      mdog = 1'b1;
      mode = axis_status_pkg::MODE_REF_RET;
      fsp = 8'h01;
      cyc(1);
      chk(sel, 8'h01);
      ndog = 8'h01;
      cyc(1);
      chk(creep, 8'h01);
      fsp = '0;
      cyc(1);
      chk(sel, 8'h01);
      r1 = 8'h01;
      cyc(1);
      r1 = '0;
      ndog = '0;
      chk(f1, 8'h01);
      chk(coord, 8'h01);
      chk(creep, 8'h00);
      cyc(1);
      chk(sel, 8'h00);
      {fsp, ndog} = 16'h0101;
      cyc(2);
      chk(creep, 8'h00);
      {fsp, ndog} = '0;
      mode = axis_status_pkg::MODE_JOG;
      r1 = 8'h02;
      cyc(1);
      r1 = '0;
      cyc(1);
      chk(f1, 8'h01);
      mode = axis_status_pkg::MODE_AUTO;
      move(8'h02, axis_status_pkg::CMD_REF2, 1'b0);
      chk(sel, 8'h02);
      // Arrival lands with the completion pulse, while the return is still pending
      for (int k = 0; k < 200 && done === '0; k++) begin
         cyc(1);
      end
      r2 = 8'h02;
      cyc(1);
      r2 = 8'h04;
      chk(f2, 8'h02);
      cyc(1);
      r2 = '0;
      cyc(1);
      chk(f2, 8'h02);
      move(8'h01, axis_status_pkg::CMD_MOVE, 1'b0);
      cyc(2);
      chk(f1, 8'h00);
      wait_done();
      $display("test reference ended");
      move(8'h40, axis_status_pkg::CMD_MOVE, 1'b0);
      crst = 1'b1;
      cyc(1);
      crst = 1'b0;
      chk(sel, 8'h00);
      wait_done();
      move(8'h04, axis_status_pkg::CMD_MOVE, 1'b0);
      // Five cycles of stop so the checker's stop property is exercised
      emg = 1'b1;
      cyc(5);
      chk(sel | f2, 8'h00);
      chk(rdy, 8'h00);
      emg = 1'b0;
      cyc(4);
      chk(rdy, 8'hFF);
      $display("test stop ended");
      wrap_up();
   end
endmodule
